// >>> hw/sit_pkg.sv
// shared constants and types for the simplified i2c transmit channel
package sit_pkg;
	// ==========================================================
	// register word offsets (word addresses)
	localparam logic [3:0] OFS_OUT_LEVELS  = 4'h0;
	localparam logic [3:0] OFS_OUT_ENABLES = 4'h1;
	localparam logic [3:0] OFS_RUN_TRIGGER = 4'h2;
	localparam logic [3:0] OFS_MODE_CFG    = 4'h3;
	localparam logic [3:0] OFS_COMM_CFG    = 4'h4;
	localparam logic [3:0] OFS_DATA_DIV    = 4'h5;
	localparam logic [3:0] OFS_IRQ_STATUS  = 4'h6;
	localparam logic [3:0] OFS_IRQ_ENABLE  = 4'h7;
	localparam logic [3:0] OFS_IRQ_CLEAR   = 4'h8;
	localparam logic [3:0] OFS_CHAN_STATUS = 4'h9;
	// ==========================================================
	// field positions
	localparam int BIT_DATA_LEVEL   = 0;
	localparam int BIT_CLOCK_LEVEL  = 8;
	localparam int BIT_DRIVE_EN     = 0;
	localparam int BIT_RUN_TRIG     = 0;
	localparam int BIT_HALT_TRIG    = 1;
	localparam int BIT_TX_ENABLE    = 15;
	localparam int BIT_RX_ENABLE    = 14;
	localparam int DIV_LSB          = 9;
	localparam int IRQ_BIT_END      = 0;
	localparam int IRQ_BIT_ACKERR   = 1;
	// ==========================================================
	// reset values
	localparam logic [15:0] RST_OUT_LEVELS = 16'h0f0f;
	localparam logic [15:0] RST_MODE_CFG   = 16'h0020;
	localparam logic [15:0] RST_COMM_CFG   = 16'h8017;
	localparam logic [15:0] RST_DATA_DIV   = 16'h0200;
	// ==========================================================
	// frame shape
	localparam logic [3:0] FRAME_BITS = 4'h8;
	localparam logic [3:0] SLOT_LAST  = 4'h8;
	localparam int         SYNC_DEPTH = 2;
	localparam logic [1:0] IRQ_ZERO   = 2'h0;

	typedef enum logic [1:0] {
		SIT_IDLE,
		SIT_LOW,
		SIT_HIGH
	} sit_state_e;

	// bus-side pin drive (open drain: enable means pull low)
	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} sit_pins_s;
endpackage : sit_pkg

// >>> hw/sit_core.sv
// simplified i2c master transmit channel with avalon-mm register slave
`timescale 1ns/1ns
// Notes on behaviour
// - supports address send, data send and stop, each sequenced by software.
// - after software start, first frame holds seven address bits and one direction bit.
// - every frame is eight bits; address frame carries direction in bit zero.
// - only the transfer-end and ack error interrupts exist; no buffer-empty interrupt is offered.
// - a high level sampled in the ack slot sets the ack error flag.
// - data driven non-inverted, idles at the data level bit (high after reset), msb first, no parity bit.
// - a ninth slot follows each frame with data released to sample ack.
// - after the last byte software stops the channel and both lines return to the level bits.
// - master only; no arbitration loss, slave mode or clock stretch detection.
// - the ack error flag is the channel's only error indication.
module sit_core (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// bus pins
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             scl_o,
	output logic             scl_oe,
	output logic             sda_o,
	output logic             sda_oe,
	// interrupt
	output logic             irq
);
	// ==========================================================
	// registers
	logic [15:0]        out_levels_r;
	logic               drive_en_r;
	logic [15:0]        mode_cfg_r;
	logic [15:0]        comm_cfg_r;
	logic [15:0]        data_div_r;
	logic               running_r;
	logic [1:0]         irq_status_r;
	logic [1:0]         irq_enable_r;
	logic               ack_error_flag_r;
	logic               ack_pending_r;
	logic [7:0]         shift_r;
	logic [3:0]         slot_r;
	logic [6:0]         div_cnt_r;
	logic               frame_end_r;
	logic               ack_bad_r;
	logic [1:0]         sda_sync_r;
	logic [1:0]         scl_sync_r;
	sit_pkg::sit_state_e state_r;
	sit_pkg::sit_pins_s  pins_r;
	logic               ack_answered_r;
	logic               halt_pending_r;

	logic wr_hit;
	logic rd_hit;
	assign wr_hit = avs_write && !avs_waitrequest;
	assign rd_hit = avs_read && avs_waitrequest;

	function automatic logic hit(input logic [3:0] ofs);
		hit = wr_hit && (avs_address == ofs);
	endfunction : hit

	// ==========================================================
	// bus slave: one wait state, answer on the second edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0;
		end else if (rd_hit) begin
			unique case (avs_address)
				sit_pkg::OFS_OUT_LEVELS:  avs_readdata <= {16'h0, out_levels_r};
				sit_pkg::OFS_OUT_ENABLES: avs_readdata <= {31'h0, drive_en_r};
				sit_pkg::OFS_MODE_CFG:    avs_readdata <= {16'h0, mode_cfg_r};
				sit_pkg::OFS_COMM_CFG:    avs_readdata <= {16'h0, comm_cfg_r};
				sit_pkg::OFS_DATA_DIV:    avs_readdata <= {16'h0, data_div_r};
				sit_pkg::OFS_IRQ_STATUS:  avs_readdata <= {30'h0, irq_status_r};
				sit_pkg::OFS_IRQ_ENABLE:  avs_readdata <= {30'h0, irq_enable_r};
				sit_pkg::OFS_CHAN_STATUS: avs_readdata <= {29'h0, ack_error_flag_r, running_r,
					state_r != sit_pkg::SIT_IDLE};
				default:                  avs_readdata <= 32'h0;
			endcase
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_levels_r <= sit_pkg::RST_OUT_LEVELS;
			drive_en_r   <= 1'b0;
			mode_cfg_r   <= sit_pkg::RST_MODE_CFG;
			comm_cfg_r   <= sit_pkg::RST_COMM_CFG;
			irq_enable_r <= sit_pkg::IRQ_ZERO;
		end else begin
			if (hit(sit_pkg::OFS_OUT_LEVELS)) begin
				out_levels_r <= avs_writedata[15:0];
			end
			if (hit(sit_pkg::OFS_OUT_ENABLES)) begin
				drive_en_r <= avs_writedata[sit_pkg::BIT_DRIVE_EN];
			end
			if (hit(sit_pkg::OFS_MODE_CFG)) begin
				mode_cfg_r <= avs_writedata[15:0];
			end
			if (hit(sit_pkg::OFS_COMM_CFG)) begin
				comm_cfg_r <= avs_writedata[15:0];
			end
			if (hit(sit_pkg::OFS_IRQ_ENABLE)) begin
				irq_enable_r <= avs_writedata[1:0];
			end
		end
	end

	// divisor in upper seven bits, bit 8 reads zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_div_r <= sit_pkg::RST_DATA_DIV;
		end else if (hit(sit_pkg::OFS_DATA_DIV)) begin
			data_div_r <= {avs_writedata[15:9], 1'b0, avs_writedata[7:0]};
		end
	end

	// run and halt triggers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			running_r <= 1'b0;
		end else if (hit(sit_pkg::OFS_RUN_TRIGGER) && avs_writedata[sit_pkg::BIT_HALT_TRIG]) begin
			running_r <= 1'b0;
		end else if (hit(sit_pkg::OFS_RUN_TRIGGER) && avs_writedata[sit_pkg::BIT_RUN_TRIG]) begin
			running_r <= 1'b1;
		end
	end

	// ==========================================================
	// input synchronisers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sda_sync_r <= 2'h3;
			scl_sync_r <= 2'h3;
		end else begin
			sda_sync_r <= {sda_sync_r[0], sda_i};
			scl_sync_r <= {scl_sync_r[0], scl_i};
		end
	end

	// ==========================================================
	// frame engine: each half bit lasts divisor+1 clocks
	logic start_frame;
	logic half_done;
	assign start_frame = hit(sit_pkg::OFS_DATA_DIV) && running_r
		&& comm_cfg_r[sit_pkg::BIT_TX_ENABLE] && (state_r == sit_pkg::SIT_IDLE);
	assign half_done = (div_cnt_r == data_div_r[15:9]);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= sit_pkg::SIT_IDLE;
			div_cnt_r   <= 7'h0;
			slot_r      <= 4'h0;
			shift_r     <= 8'hff;
			frame_end_r <= 1'b0;
			ack_bad_r   <= 1'b0;
		end else begin
			frame_end_r <= 1'b0;
			ack_bad_r   <= 1'b0;
			unique case (state_r)
				sit_pkg::SIT_IDLE: begin
					if (start_frame) begin
						shift_r   <= avs_writedata[7:0];
						slot_r    <= 4'h0;
						div_cnt_r <= 7'h0;
						state_r   <= sit_pkg::SIT_LOW;
					end
				end
				sit_pkg::SIT_LOW: begin
					div_cnt_r <= half_done ? 7'h0 : div_cnt_r + 7'h1;
					if (!running_r) begin
						state_r <= sit_pkg::SIT_IDLE;
					end else if (half_done) begin
						state_r <= sit_pkg::SIT_HIGH;
					end
				end
				sit_pkg::SIT_HIGH: begin
					div_cnt_r <= half_done ? 7'h0 : div_cnt_r + 7'h1;
					if (!running_r) begin
						state_r <= sit_pkg::SIT_IDLE;
					end else if (half_done) begin
						if (slot_r == sit_pkg::SLOT_LAST) begin
							ack_bad_r   <= sda_sync_r[1];
							frame_end_r <= 1'b1;
							state_r     <= sit_pkg::SIT_IDLE;
						end else begin
							shift_r <= {shift_r[6:0], 1'b1};
							slot_r  <= slot_r + 4'h1;
							state_r <= sit_pkg::SIT_LOW;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// ack error flag: set wins over clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_error_flag_r <= 1'b0;
		end else if (ack_bad_r) begin
			ack_error_flag_r <= 1'b1;
		end else if (hit(sit_pkg::OFS_IRQ_CLEAR) && avs_writedata[sit_pkg::IRQ_BIT_ACKERR]) begin
			ack_error_flag_r <= 1'b0;
		end
	end

	// sticky interrupt status, set wins over clear
	logic [1:0] irq_events;
	logic [1:0] irq_clear;
	assign irq_events = {ack_bad_r, frame_end_r};
	assign irq_clear  = hit(sit_pkg::OFS_IRQ_CLEAR) ? avs_writedata[1:0] : sit_pkg::IRQ_ZERO;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_r <= sit_pkg::IRQ_ZERO;
			irq          <= 1'b0;
		end else begin
			irq_status_r <= (irq_status_r & ~irq_clear) | irq_events;
			irq          <= |(((irq_status_r & ~irq_clear) | irq_events) & irq_enable_r);
		end
	end

	// ==========================================================
	// pin drive; no stretch or arbitration sensing on scl
	// idle lines keep the level bits, so start and stop stay with software
	logic data_bit;
	logic clk_bit;
	always_comb begin
		data_bit = out_levels_r[sit_pkg::BIT_DATA_LEVEL];
		clk_bit  = out_levels_r[sit_pkg::BIT_CLOCK_LEVEL];
		if (drive_en_r && state_r != sit_pkg::SIT_IDLE) begin
			clk_bit  = (state_r == sit_pkg::SIT_HIGH);
			data_bit = (slot_r == sit_pkg::SLOT_LAST) ? 1'b1 : shift_r[7];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pins_r <= '{scl_o: 1'b0, scl_oe: 1'b0, sda_o: 1'b0, sda_oe: 1'b0};
		end else begin
			pins_r.scl_o  <= 1'b0;
			pins_r.sda_o  <= 1'b0;
			pins_r.scl_oe <= !clk_bit;
			pins_r.sda_oe <= !data_bit;
		end
	end
	assign scl_o  = pins_r.scl_o;
	assign scl_oe = pins_r.scl_oe;
	assign sda_o  = pins_r.sda_o;
	assign sda_oe = pins_r.sda_oe;

	// ==========================================================
	// checks
	sequence s_last_high;
		state_r == sit_pkg::SIT_HIGH && slot_r == sit_pkg::SLOT_LAST && half_done && running_r;
	endsequence

	chk_ack_error_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s_last_high and sda_sync_r[1]) |=> ##1 ack_error_flag_r)
		else $error("ack error flag not set");
	chk_ack_good: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s_last_high and !sda_sync_r[1]) |=> !ack_bad_r)
		else $error("ack error raised on a good ack");
	chk_end_event: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_last_high |=> frame_end_r ##1 irq_status_r[sit_pkg::IRQ_BIT_END])
		else $error("transfer end not raised");
	chk_ack_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_r != sit_pkg::SIT_IDLE && slot_r == sit_pkg::SLOT_LAST && drive_en_r |=> !sda_oe)
		else $error("data held low in ack slot");
	chk_msb_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_r == sit_pkg::SIT_IDLE && start_frame && drive_en_r |=> shift_r == $past(avs_writedata[7:0])
		##1 sda_oe == !shift_r[7])
		else $error("first bit not msb");
	chk_div_bit8: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!data_div_r[8])
		else $error("divisor bit 8 not zero");
	chk_manual_lines: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!drive_en_r && !$past(drive_en_r) |=> scl_oe == !$past(out_levels_r[sit_pkg::BIT_CLOCK_LEVEL]))
		else $error("clock line not following level bit");
	chk_manual_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!drive_en_r && !$past(drive_en_r) |=> sda_oe == !$past(out_levels_r[sit_pkg::BIT_DATA_LEVEL]))
		else $error("data line not following level bit");
	chk_idle_levels: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_r == sit_pkg::SIT_IDLE |=> scl_oe == !$past(out_levels_r[sit_pkg::BIT_CLOCK_LEVEL]))
		else $error("idle clock line not at level bit");
	chk_open_drain: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!scl_o && !sda_o)
		else $error("line driven high");
	chk_slot_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
		slot_r <= sit_pkg::SLOT_LAST)
		else $error("slot beyond the ack slot");
	chk_slot_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_r == sit_pkg::SIT_HIGH && half_done && running_r && slot_r != sit_pkg::SLOT_LAST
		|=> state_r == sit_pkg::SIT_LOW && slot_r == $past(slot_r) + 4'h1)
		else $error("slot did not advance");
	chk_shift_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_r == sit_pkg::SIT_HIGH && half_done && running_r && slot_r != sit_pkg::SLOT_LAST
		|=> shift_r == (($past(shift_r) << 1) | 8'h01))
		else $error("shift not msb first");
	chk_halt_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		running_r ##1 !running_r |=> state_r == sit_pkg::SIT_IDLE)
		else $error("frame not ended by halt");
	chk_halt_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hit(sit_pkg::OFS_RUN_TRIGGER) && avs_writedata[sit_pkg::BIT_HALT_TRIG] |=> !running_r)
		else $error("halt trigger ignored");
	chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		|(irq_status_r & irq_enable_r) && !hit(sit_pkg::OFS_IRQ_CLEAR) && !$rose(|irq_enable_r)
		|-> irq)
		else $error("interrupt low while enabled status set");
	chk_irq_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(|(irq_status_r & irq_enable_r)) && !(|irq_events) |=> !irq)
		else $error("interrupt high with no enabled status");
	chk_no_stretch: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_r == sit_pkg::SIT_LOW && half_done && running_r |=> state_r == sit_pkg::SIT_HIGH)
		else $error("clock waited on bus");
	chk_addr_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start_frame |=> state_r == sit_pkg::SIT_LOW && slot_r == 4'h0)
		else $error("frame did not start");
	chk_wait_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered");
	chk_wait_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer held too long");
endmodule : sit_core

// >>> verification/sit_slave.sv
// behavioural i2c slave that acknowledges or refuses each byte
`timescale 1ns/1ns
module sit_slave (
	// bus lines
	input  wire logic       scl,
	input  wire logic       sda,
	// control and observation
	input  wire logic       nack,
	output logic            sda_pull,
	output logic [7:0]      got_byte,
	output logic [3:0]      rises
);
	logic [7:0] shift_r;
	initial begin
		sda_pull = 1'b0;
		shift_r = 8'h00;
		got_byte = 8'h00;
		rises = 4'h0;
	end
	// ==========================================================
	// start or stop: data edge while clock is high restarts the count
	// settle one step so a data change riding a clock fall is not taken
	always @(sda) begin
		#1;
		if (scl === 1'b1) begin
			rises = 4'h0;
		end
	end
	// ==========================================================
	// sample on rising clock, eight bits then the ack slot
	always @(posedge scl) begin
		rises = (rises == 4'h9) ? 4'h1 : rises + 4'h1;
		if (rises <= 4'h8) begin
			shift_r = {shift_r[6:0], sda};
		end
		if (rises == 4'h8) begin
			got_byte = shift_r;
		end
	end
	// change the data line only while the clock is low
	always @(negedge scl) begin
		sda_pull = (rises == 4'h8) && !nack;
	end
endmodule : sit_slave

// >>> verification/test_sit_core.sv
// self-checking bench for the i2c transmit channel
`timescale 1ns/1ns
module test_sit_core;
	typedef struct packed {
		logic        wr;
		logic [3:0]  a;
		logic [15:0] d;
		logic [15:0] exp;
	} sit_row_s;
	logic        clk_sys;
	logic        rst_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        scl_o;
	logic        scl_oe;
	logic        sda_o;
	logic        sda_oe;
	logic        irq;
	logic        nack;
	logic        sda_pull;
	logic [7:0]  got_byte;
	logic [3:0]  rises;
	logic [31:0] rd;
	int          n_fail;
	int          checks;
	int          cycles;
	time         t_rise;
	time         scl_per;
	wire         scl_w = ~scl_oe;
	wire         sda_w = ~(sda_oe | sda_pull);
	sit_row_s    rows [9] = '{
		'{1'b0, sit_pkg::OFS_OUT_LEVELS, 16'h0000, 16'h0f0f},
		'{1'b0, sit_pkg::OFS_MODE_CFG, 16'h0000, 16'h0020},
		'{1'b0, sit_pkg::OFS_COMM_CFG, 16'h0000, 16'h8017},
		'{1'b0, sit_pkg::OFS_DATA_DIV, 16'h0000, 16'h0200},
		'{1'b0, sit_pkg::OFS_IRQ_STATUS, 16'h0000, 16'h0000},
		'{1'b0, sit_pkg::OFS_CHAN_STATUS, 16'h0000, 16'h0000},
		'{1'b0, 4'hf, 16'h0000, 16'h0000},
		'{1'b1, 4'hc, 16'hffff, 16'h0000},
		'{1'b1, sit_pkg::OFS_IRQ_ENABLE, 16'h0003, 16'h0003}};
	sit_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	sit_slave slave (.scl(scl_w), .sda(sda_w), .nack(nack), .sda_pull(sda_pull), .got_byte(got_byte),
		.rises(rises));
	// ==========================================================
	// clock, bus clock period monitor, timeout
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge scl_w) begin
		scl_per = $time - t_rise;
		t_rise = $time;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			test_done();
		end
	end
	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus(1'b1, a, {16'h0000, d});
	endtask : wr
	task automatic rdreg(input logic [3:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rdreg
	task automatic lines(input logic scl_exp, input logic sda_exp);
		repeat (3) @(posedge clk_sys);
		check({31'h0, scl_w}, {31'h0, scl_exp});
		check({31'h0, sda_w}, {31'h0, sda_exp});
	endtask : lines
	task automatic send(input logic [7:0] b, input logic nk);
		nack <= nk;
		wr(sit_pkg::OFS_DATA_DIV, {7'h03, 1'b0, b});
		do begin
			rdreg(sit_pkg::OFS_CHAN_STATUS);
		end while (rd[0] !== 1'b0);
		check({24'h0, got_byte}, {24'h0, b});
		check({28'h0, rises}, 32'h9);
		check(32'(scl_per), 32'ha0);
		$display("frame %h done", b);
	endtask : send
	task automatic test_done;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		nack = 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		lines(1'b1, 1'b1);
		check({31'h0, irq}, 32'h0);
		check({31'h0, scl_o | sda_o}, 32'h0);
		$display("reset test done");
		repeat (4) @(posedge clk_sys);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].a, rows[i].d);
			end
			rdreg(rows[i].a);
			check(rd, {16'h0000, rows[i].exp});
		end
		$display("register test done");
		// start condition from level bits, then frames
		wr(sit_pkg::OFS_OUT_LEVELS, 16'h0f0e);
		lines(1'b1, 1'b0);
		wr(sit_pkg::OFS_OUT_LEVELS, 16'h0e0e);
		lines(1'b0, 1'b0);
		wr(sit_pkg::OFS_OUT_ENABLES, 16'h0001);
		wr(sit_pkg::OFS_RUN_TRIGGER, 16'h0001);
		send(8'ha1, 1'b0);
		check({31'h0, irq}, 32'h1);
		rdreg(sit_pkg::OFS_IRQ_STATUS);
		check(rd, 32'h1);
		wr(sit_pkg::OFS_IRQ_CLEAR, 16'h0003);
		wr(sit_pkg::OFS_IRQ_ENABLE, 16'h0000);
		send(8'h5a, 1'b1);
		check({31'h0, irq}, 32'h0);
		rdreg(sit_pkg::OFS_CHAN_STATUS);
		check({31'h0, rd[2]}, 32'h1);
		rdreg(sit_pkg::OFS_IRQ_STATUS);
		check(rd, 32'h3);
		wr(sit_pkg::OFS_IRQ_ENABLE, 16'h0002);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h1);
		wr(sit_pkg::OFS_IRQ_CLEAR, 16'h0003);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0);
		wr(sit_pkg::OFS_IRQ_ENABLE, 16'h0003);
		send(8'h81, 1'b0);
		rdreg(sit_pkg::OFS_IRQ_STATUS);
		check(rd, 32'h1);
		$display("frame test done");
		// halted channel ignores a data write, then stop condition
		wr(sit_pkg::OFS_RUN_TRIGGER, 16'h0002);
		wr(sit_pkg::OFS_DATA_DIV, 16'h0655);
		rdreg(sit_pkg::OFS_CHAN_STATUS);
		check({30'h0, rd[1:0]}, 32'h0);
		wr(sit_pkg::OFS_OUT_ENABLES, 16'h0000);
		wr(sit_pkg::OFS_OUT_LEVELS, 16'h0f0e);
		wr(sit_pkg::OFS_OUT_LEVELS, 16'h0f0f);
		lines(1'b1, 1'b1);
		$display("stop test done");
		test_done();
	end
endmodule : test_sit_core
